// ===== logic/bbc_exec.sv
`timescale 1ns/1ps
// executes one instruction written over apb, then goes idle again
module bbc_exec (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // program memory read port, data one cycle after the address
    output logic      [15:0] pmem_addr,
    output logic             pmem_re,
    input  wire logic [7:0]  pmem_rdata
);
    import bbc_pkg::*;

    bbc_regs_type state_ff;
    bbc_regs_type nxt_state;
    bbc_bit_if    bit_ch ();

    // **************************************************************
    // helpers
    // **************************************************************
    // register space read: file at 00-0f, flags word at d5, rest zero
    function automatic logic [7:0] get_reg(bbc_regs_type s,
                                           logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == FLAGS_ADDR) begin
            v = s.flags;
        end else if (a < 8'(REG_N)) begin
            v = s.regs[a[3:0]];
        end
        return v;
    endfunction

    // register space write, unmapped addresses are dropped
    function automatic bbc_regs_type put_reg(bbc_regs_type s,
                                             logic [7:0] a,
                                             logic [7:0] v);
        bbc_regs_type r;
        r = s;
        if (a == FLAGS_ADDR) begin
            r.flags = v;
        end else if (a < 8'(REG_N)) begin
            r.regs[a[3:0]] = v;
        end
        return r;
    endfunction

    // cycle budget of an opcode, zero marks an unknown opcode
    function automatic logic [3:0] op_cycles(logic [7:0] op);
        logic [3:0] c;
        c = 4'd0;
        if (op == OP_BTJR) begin
            c = CYC_BTJR;
        end else if (op == OP_BIT_EXCLUSIVE_OR) begin
            c = CYC_BIT_EXCLUSIVE_OR;
        end else if (op == OP_CALL_DA) begin
            c = CYC_CALL_DA;
        end else if (op == OP_CALL_IRR) begin
            c = CYC_CALL_IR;
        end else if (op == OP_CALL_IA) begin
            c = CYC_CALL_IA;
        end else if (op == OP_CCF || op == OP_CLR_R
                     || op == OP_CLR_IR) begin
            c = CYC_SHORT;
        end
        return c;
    endfunction

    // apb read mux, returns {error, data}
    function automatic logic [32:0] apb_read(bbc_regs_type s,
                                             logic [9:0] idx);
        logic [32:0] r;
        r = {1'b0, 32'h0000_0000};
        if (idx == IDX_CTRL) begin
            r[STAT_BUSY]  = (s.st != ST_IDLE);
            r[STAT_TAKEN] = s.taken;
            r[STAT_ILL]   = s.illegal;
        end else if (idx == IDX_INSTR) begin
            r[23:0] = s.instr;
        end else if (idx == IDX_PC) begin
            r[15:0] = s.pc;
        end else if (idx == IDX_SP) begin
            r[15:0] = s.sp;
        end else if (idx == IDX_FLAGS) begin
            r[7:0] = s.flags;
        end else if (idx >= IDX_REGS && idx < IDX_REGS + 10'(REG_N)) begin
            r[7:0] = s.regs[idx[3:0]];
        end else if (idx >= IDX_STACK
                     && idx < IDX_STACK + 10'(STACK_N)) begin
            r[7:0] = s.stack[idx[3:0]];
        end else begin
            r[32] = 1'b1;
        end
        return r;
    endfunction

    // **************************************************************
    // bit datapath
    // **************************************************************
    // operands: working register from byte two, other from byte three
    assign bit_ch.work_val  = get_reg(state_ff,
                                      {4'h0, state_ff.instr[15:12]});
    assign bit_ch.other_val = get_reg(state_ff, state_ff.instr[23:16]);
    assign bit_ch.bit_idx   = state_ff.instr[11:9];
    assign bit_ch.sel       = state_ff.instr[8];

    bbc_bitop u_bitop (
        .bi (bit_ch.unit)
    );

    // **************************************************************
    // next state
    // **************************************************************
    // one pass: instruction sequencer first, then the apb slave
    always_comb begin
        logic [7:0]  op;
        logic [7:0]  b1;
        logic [7:0]  b2;
        logic [7:0]  ptr;
        logic [15:0] disp;
        logic [32:0] rd;
        logic [9:0]  idx;
        op   = state_ff.instr[7:0];
        b1   = state_ff.instr[15:8];
        b2   = state_ff.instr[23:16];
        ptr  = 8'h00;
        disp = {{8{b2[7]}}, b2};
        rd   = 33'h0_0000_0000;
        idx  = paddr[11:2];
        nxt_state = state_ff;
        nxt_state.pmem_re = 1'b0;

        // cycle budget runs down in every busy state
        if (state_ff.st != ST_IDLE && state_ff.cyc != 4'd0) begin
            nxt_state.cyc = state_ff.cyc - 4'd1;
        end

        case (state_ff.st)
            ST_IDLE: begin
                nxt_state.st = ST_IDLE;
            end
            ST_DECODE: begin
                nxt_state.st = ST_WAIT;
                if (op == OP_BTJR) begin
                    // both forms: branch when tested bit equals selector
                    nxt_state.pc    = state_ff.pc + LEN_3;
                    nxt_state.taken = (bit_ch.test_bit == bit_ch.sel);
                    if (bit_ch.test_bit == bit_ch.sel) begin
                        nxt_state.pc = state_ff.pc + LEN_3 + disp;
                    end
                end else if (op == OP_BIT_EXCLUSIVE_OR) begin
                    if (!bit_ch.sel) begin
                        nxt_state = put_reg(nxt_state, {4'h0, b1[7:4]},
                                            bit_ch.xor_byte);
                    end else begin
                        nxt_state = put_reg(nxt_state, b2,
                                            bit_ch.xor_byte);
                    end
                    // flags last, so they win over a write to d5
                    nxt_state.flags[FLG_Z] = ~bit_ch.xor_bit;
                    nxt_state.flags[FLG_S] = 1'b0;
                    nxt_state.pc = state_ff.pc + LEN_3;
                end else if (op == OP_CALL_DA) begin
                    nxt_state.pc  = state_ff.pc + LEN_3;
                    nxt_state.tgt = {b1, b2};
                    nxt_state.st  = ST_PUSH_LO;
                end else if (op == OP_CALL_IRR) begin
                    nxt_state.pc  = state_ff.pc + LEN_2;
                    nxt_state.tgt = {get_reg(state_ff, b1),
                                     get_reg(state_ff, b1 + 8'h01)};
                    nxt_state.st  = ST_PUSH_LO;
                end else if (op == OP_CALL_IA) begin
                    nxt_state.pc        = state_ff.pc + LEN_2;
                    nxt_state.pmem_addr = {8'h00, b1};
                    nxt_state.pmem_re   = 1'b1;
                    nxt_state.st        = ST_VEC_A;
                end else if (op == OP_CCF) begin
                    nxt_state.flags[FLG_C] = ~state_ff.flags[FLG_C];
                    nxt_state.pc = state_ff.pc + LEN_1;
                end else if (op == OP_CLR_R) begin
                    nxt_state = put_reg(nxt_state, b1, 8'h00);
                    nxt_state.pc = state_ff.pc + LEN_2;
                end else if (op == OP_CLR_IR) begin
                    // pointer register only read, written only when it points at itself
                    ptr = get_reg(state_ff, b1);
                    nxt_state = put_reg(nxt_state, ptr, 8'h00);
                    nxt_state.pc = state_ff.pc + LEN_2;
                end else begin
                    nxt_state.illegal = 1'b1;
                    nxt_state.cyc     = 4'd0;
                end
            end
            ST_VEC_A: begin
                // second vector byte addressed, first arrives next cycle
                nxt_state.pmem_addr = state_ff.pmem_addr + 16'h0001;
                nxt_state.pmem_re   = 1'b1;
                nxt_state.st        = ST_VEC_B;
            end
            ST_VEC_B: begin
                nxt_state.tgt[15:8] = pmem_rdata;
                nxt_state.st        = ST_VEC_C;
            end
            ST_VEC_C: begin
                nxt_state.tgt[7:0] = pmem_rdata;
                nxt_state.st       = ST_PUSH_LO;
            end
            ST_PUSH_LO: begin
                nxt_state.sp = state_ff.sp - 16'h0001;
                nxt_state.stack[nxt_state.sp[3:0]] = state_ff.pc[7:0];
                nxt_state.st = ST_PUSH_HI;
            end
            ST_PUSH_HI: begin
                nxt_state.sp = state_ff.sp - 16'h0001;
                nxt_state.stack[nxt_state.sp[3:0]] = state_ff.pc[15:8];
                nxt_state.pc = state_ff.tgt;
                nxt_state.st = ST_WAIT;
            end
            ST_WAIT: begin
                if (state_ff.cyc == 4'd0) begin
                    nxt_state.st = ST_IDLE;
                end
            end
            default: begin
                nxt_state.st = ST_IDLE;
            end
        endcase

        // apb setup phase: decode and answer in the access phase
        if (psel && !penable) begin
            rd = apb_read(state_ff, idx);
            nxt_state.pready  = 1'b1;
            nxt_state.prdata  = rd[31:0];
            // state is frozen for software while an instruction runs
            nxt_state.pslverr = rd[32] || (pwrite && idx != IDX_CTRL
                                           && state_ff.st != ST_IDLE);
        end else if (psel && penable && state_ff.pready) begin
            nxt_state.pready  = 1'b0;
            nxt_state.pslverr = 1'b0;
            if (pwrite && !state_ff.pslverr) begin
                if (idx == IDX_CTRL) begin
                    if (pwdata[CTRL_GO] && state_ff.st == ST_IDLE) begin
                        nxt_state.st      = ST_DECODE;
                        nxt_state.taken   = 1'b0;
                        nxt_state.illegal = 1'b0;
                        nxt_state.cyc     = op_cycles(op) - 4'd1;
                    end
                end else if (idx == IDX_INSTR) begin
                    nxt_state.instr = pwdata[23:0];
                end else if (idx == IDX_PC) begin
                    nxt_state.pc = pwdata[15:0];
                end else if (idx == IDX_SP) begin
                    nxt_state.sp = pwdata[15:0];
                end else if (idx == IDX_FLAGS) begin
                    nxt_state.flags = pwdata[7:0];
                end else if (idx < IDX_STACK) begin
                    nxt_state.regs[idx[3:0]] = pwdata[7:0];
                end else begin
                    nxt_state.stack[idx[3:0]] = pwdata[7:0];
                end
            end
        end else begin
            nxt_state.pready  = 1'b0;
            nxt_state.pslverr = 1'b0;
        end
    end

    // **************************************************************
    // state register
    // **************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff       <= '0;
            state_ff.st    <= ST_IDLE;
            state_ff.pc    <= PC_RST;
            state_ff.sp    <= SP_RST;
            state_ff.flags <= FLAGS_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // outputs straight from the state register
    assign prdata    = state_ff.prdata;
    assign pready    = state_ff.pready;
    assign pslverr   = state_ff.pslverr;
    assign pmem_addr = state_ff.pmem_addr;
    assign pmem_re   = state_ff.pmem_re;
endmodule

// ===== logic/bbc_pkg.sv
// Summary of operation
// - bit test branch set form adds signed displacement to pc when bit is one
// - bit test branch is three bytes, ten cycles, opcode 37, flags untouched
// - second byte holds 4-bit register, 3-bit bit index, one selector bit
// - displacement is signed 8-bit, reach -128 to +127 from next pc
// - selector zero gives clear form, branching when tested bit is zero
// - bit xor into bit zero or into indexed bit, other bits kept
// - bit xor sets zero on zero result, clears sign, keeps c, d, h
// - bit xor is three bytes, six cycles, second byte register/bit/selector
// - call pushes return low byte, then high byte, then loads target
// - pushed return address is the address after the call
// - call forms F6 direct 3/14, F4 pair 2/12, D4 vector 2/14
// - vector call reads high byte at lower address; calls keep flags
// - complement carry inverts carry only, one byte, opcode EF, 4 cycles
// - clear writes zero, no flags, two bytes, 4 cycles, B0 and B1
// - pointer clear zeroes the pointed register, pointer itself kept unless it points at itself
package bbc_pkg;
    // ****************************************************************
    // opcodes, lengths and cycle counts
    // ****************************************************************
    localparam logic [7:0] OP_BTJR     = 8'h37;
    localparam logic [7:0] OP_BIT_EXCLUSIVE_OR     = 8'h27;
    localparam logic [7:0] OP_CALL_DA  = 8'hF6;
    localparam logic [7:0] OP_CALL_IRR = 8'hF4;
    localparam logic [7:0] OP_CALL_IA  = 8'hD4;
    localparam logic [7:0] OP_CCF      = 8'hEF;
    localparam logic [7:0] OP_CLR_R    = 8'hB0;
    localparam logic [7:0] OP_CLR_IR   = 8'hB1;
    localparam logic [15:0] LEN_1 = 16'h0001;
    localparam logic [15:0] LEN_2 = 16'h0002;
    localparam logic [15:0] LEN_3 = 16'h0003;
    localparam logic [3:0] CYC_BTJR    = 4'd10;
    localparam logic [3:0] CYC_BIT_EXCLUSIVE_OR    = 4'd6;
    localparam logic [3:0] CYC_CALL_DA = 4'd14;
    localparam logic [3:0] CYC_CALL_IR = 4'd12;
    localparam logic [3:0] CYC_CALL_IA = 4'd14;
    localparam logic [3:0] CYC_SHORT   = 4'd4;
    // ****************************************************************
    // flags word layout and reset values
    // ****************************************************************
    localparam int FLG_C = 7;
    localparam int FLG_Z = 6;
    localparam int FLG_S = 5;
    localparam logic [7:0]  FLAGS_ADDR = 8'hD5;
    localparam logic [7:0]  FLAGS_RST  = 8'h00;
    localparam logic [15:0] PC_RST     = 16'h0000;
    localparam logic [15:0] SP_RST     = 16'h0000;
    localparam int REG_N   = 16;
    localparam int STACK_N = 16;
    // ****************************************************************
    // apb register indices, byte address is four times the index
    // ****************************************************************
    localparam logic [9:0] IDX_CTRL  = 10'h000;
    localparam logic [9:0] IDX_INSTR = 10'h001;
    localparam logic [9:0] IDX_PC    = 10'h002;
    localparam logic [9:0] IDX_SP    = 10'h003;
    localparam logic [9:0] IDX_FLAGS = 10'h0D5;
    localparam logic [9:0] IDX_REGS  = 10'h100;
    localparam logic [9:0] IDX_STACK = 10'h180;
    localparam int CTRL_GO    = 0;
    localparam int STAT_BUSY  = 0;
    localparam int STAT_TAKEN = 1;
    localparam int STAT_ILL   = 2;

    typedef enum logic [2:0] {
        ST_IDLE, ST_DECODE, ST_VEC_A, ST_VEC_B, ST_VEC_C,
        ST_PUSH_LO, ST_PUSH_HI, ST_WAIT
    } bbc_state_type;

    typedef struct packed {
        bbc_state_type          st;
        logic [3:0]             cyc;
        logic [23:0]            instr;
        logic [15:0]            pc;
        logic [15:0]            sp;
        logic [7:0]             flags;
        logic [REG_N-1:0][7:0]  regs;
        logic [STACK_N-1:0][7:0] stack;
        logic [15:0]            tgt;
        logic [15:0]            pmem_addr;
        logic                   pmem_re;
        logic                   taken;
        logic                   illegal;
        logic [31:0]            prdata;
        logic                   pready;
        logic                   pslverr;
    } bbc_regs_type;
endpackage

// ===== logic/bbc_bit_if.sv
`timescale 1ns/1ps
// operands and results of the single-bit datapath
interface bbc_bit_if;
    logic [7:0] work_val;
    logic [7:0] other_val;
    logic [2:0] bit_idx;
    logic       sel;
    logic       test_bit;
    logic [7:0] xor_byte;
    logic       xor_bit;
    modport core (output work_val, other_val, bit_idx, sel,
                  input test_bit, xor_byte, xor_bit);
    modport unit (input work_val, other_val, bit_idx, sel,
                  output test_bit, xor_byte, xor_bit);
endinterface

// ===== logic/bbc_bitop.sv
`timescale 1ns/1ps
// single-bit test and exclusive-or, purely combinational
module bbc_bitop (
    // operand channel
    bbc_bit_if.unit bi
);
    // **************************************************************
    // bit datapath
    // **************************************************************
    // tested bit of the working register
    assign bi.test_bit = bi.work_val[bi.bit_idx];

    // xor result byte, only the chosen destination bit may change
    always_comb begin
        bi.xor_byte = bi.work_val;
        bi.xor_bit  = 1'b0;
        if (!bi.sel) begin
            bi.xor_bit     = bi.work_val[0] ^ bi.other_val[bi.bit_idx];
            bi.xor_byte    = bi.work_val;
            bi.xor_byte[0] = bi.xor_bit;
        end else begin
            bi.xor_bit  = bi.other_val[bi.bit_idx] ^ bi.work_val[0];
            bi.xor_byte = bi.other_val;
            bi.xor_byte[bi.bit_idx] = bi.xor_bit;
        end
    end
endmodule

// ===== test/bbc_exec_properties.sv
`timescale 1ns/1ps
// ****************************************************************
// port-level protocol watch for the exec block
// ****************************************************************
module bbc_props
    import bbc_pkg::*;
(
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb slave side
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // program memory port
    input wire logic [15:0] pmem_addr,
    input wire logic        pmem_re
);
    // single domain, so clocking and reset are given once
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // zero wait states: ready must follow every setup cycle
    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside an access phase");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    // the top word index is never mapped
    a_unmapped_err: assert property (psel && !penable &&
        paddr[11:2] == 10'h3FF |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    // flags and pc words carry nothing above their width
    a_flags_width: assert property (pready && !pwrite &&
        paddr[11:2] == IDX_FLAGS |-> prdata[31:8] == 24'h00_0000)
        else $error("flags read has upper bits");
    a_pc_width: assert property (pready && !pwrite &&
        paddr[11:2] == IDX_PC |-> prdata[31:16] == 16'h0000)
        else $error("pc read has upper bits");
    // vector fetch: high byte first from page zero, then the next byte
    a_vec_page: assert property ($rose(pmem_re) |->
        pmem_addr[15:8] == 8'h00)
        else $error("vector fetch outside page zero");
    a_vec_next: assert property ($rose(pmem_re) |=> pmem_re &&
        pmem_addr == $past(pmem_addr) + 16'h0001)
        else $error("second vector byte not consecutive");
    a_vec_two: assert property (pmem_re && $past(pmem_re) |=> !pmem_re)
        else $error("vector fetch longer than two reads");
endmodule

bind bbc_exec bbc_props u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pmem_addr(pmem_addr), .pmem_re(pmem_re)
);

// ===== test/tb.sv
`timescale 1ns/1ps
// ****************************************************************
// self-checking bench for the exec block
// ****************************************************************
module tb;
    import bbc_pkg::*;
    typedef struct packed {
        logic [23:0] ins;
        logic [15:0] pc;
        logic [15:0] sp;
        logic [7:0]  flg;
        logic [9:0]  i1;
        logic [7:0]  v1;
        logic [9:0]  i2;
        logic [7:0]  v2;
    } bbc_row_type;
    logic        pclk = 1'h0;
    logic        presetn = 1'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] pmem_addr;
    logic        pmem_re;
    logic [7:0]  pmem_rdata = 8'h00;
    logic [31:0] rd;
    logic        err;
    int          errors = 0;
    int          compares = 0;
    // preset: pc 1A47, sp 0002, flags AC, r0 35 r1 07 r2 03 r3 02 r7 5E
    bbc_row_type rows [13] = '{
    '{24'h10_1337,16'h1A5A,16'h0002,8'hAC,10'h101,8'h07,10'h102,8'h03},
    '{24'h80_1737,16'h1A4A,16'h0002,8'hAC,10'h101,8'h07,10'h102,8'h03},
    '{24'h80_1637,16'h19CA,16'h0002,8'hAC,10'h101,8'h07,10'h102,8'h03},
    '{24'h7F_1037,16'h1A4A,16'h0002,8'hAC,10'h101,8'h07,10'h102,8'h03},
    '{24'h7F_1337,16'h1AC9,16'h0002,8'hAC,10'h101,8'h07,10'h102,8'h03},
    '{24'h02_1227,16'h1A4A,16'h0002,8'hCC,10'h101,8'h06,10'h102,8'h03},
    '{24'h02_1527,16'h1A4A,16'h0002,8'h8C,10'h102,8'h07,10'h101,8'h07},
    '{24'h21_35F6,16'h3521,16'h0000,8'hAC,10'h181,8'h4A,10'h180,8'h1A},
    '{24'h00_00F4,16'h3507,16'h0000,8'hAC,10'h181,8'h49,10'h180,8'h1A},
    '{24'h00_40D4,16'h1A1B,16'h0000,8'hAC,10'h181,8'h49,10'h180,8'h1A},
    '{24'h00_00EF,16'h1A48,16'h0002,8'h2C,10'h101,8'h07,10'h100,8'h35},
    '{24'h00_03B0,16'h1A49,16'h0002,8'hAC,10'h103,8'h00,10'h102,8'h03},
    '{24'h00_01B1,16'h1A49,16'h0002,8'hAC,10'h107,8'h00,10'h101,8'h07}};

    bbc_exec uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pmem_addr(pmem_addr),
        .pmem_re(pmem_re), .pmem_rdata(pmem_rdata)
    );

    // ****************************************************************
    // clock and program memory
    // ****************************************************************
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    // one cycle latency; contents are a pattern, not a blank memory
    always @(posedge pclk) begin
        pmem_rdata <= pmem_addr[7:0] ^ 8'h5A;
    end

    // ****************************************************************
    // tasks
    // ****************************************************************
    task stop_test;
        if (errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until ready is seen at an edge
    task apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 8);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) begin
            errors++;
            stop_test();
        end
    endtask
    task rdchk(input logic [9:0] idx, input logic [31:0] exp);
        apb(1'h0, idx, 32'h0000_0000);
        chk(rd, exp);
    endtask
    // polls busy with a bound, since the run length is per opcode
    task wait_idle;
        int n;
        n = 0;
        do begin
            apb(1'h0, IDX_CTRL, 32'h0000_0000);
            n++;
        end while (rd[STAT_BUSY] !== 1'h0 && n < 20);
        if (rd[STAT_BUSY] !== 1'h0) begin
            errors++;
            stop_test();
        end
    endtask
    task run(input logic [23:0] ins);
        apb(1'h1, IDX_INSTR, {8'h00, ins});
        apb(1'h1, IDX_CTRL, 32'h0000_0001);
        wait_idle();
    endtask
    task preset;
        apb(1'h1, IDX_PC, 32'h0000_1A47);
        apb(1'h1, IDX_SP, 32'h0000_0002);
        apb(1'h1, IDX_FLAGS, 32'h0000_00AC);
        apb(1'h1, IDX_REGS, 32'h0000_0035);
        apb(1'h1, IDX_REGS + 10'h001, 32'h0000_0007);
        apb(1'h1, IDX_REGS + 10'h002, 32'h0000_0003);
        apb(1'h1, IDX_REGS + 10'h003, 32'h0000_0002);
        apb(1'h1, IDX_REGS + 10'h007, 32'h0000_005E);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        foreach (rows[k]) begin
            preset();
            run(rows[k].ins);
            rdchk(IDX_PC, {16'h0000, rows[k].pc});
            rdchk(IDX_SP, {16'h0000, rows[k].sp});
            rdchk(IDX_FLAGS, {24'h00_0000, rows[k].flg});
            rdchk(rows[k].i1, {24'h00_0000, rows[k].v1});
            rdchk(rows[k].i2, {24'h00_0000, rows[k].v2});
        end
        // reset while idle after the table, then a carry flip on the cleared flags
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        rdchk(IDX_FLAGS, 32'h0000_0000);
        run(24'h00_00EF);
        rdchk(IDX_FLAGS, 32'h0000_0080);
        rdchk(IDX_PC, 32'h0000_0001);
        // clear form on r0 bit 0, which reset left at zero
        run(24'h00_0037);
        chk({31'h0000_0000, rd[STAT_TAKEN]}, 32'h0000_0001);
        // unmapped word is refused both ways
        rdchk(10'h3FF, 32'h0000_0000);
        chk({31'h0000_0000, err}, 32'h0000_0001);
        apb(1'h1, 10'h3FF, 32'hFFFF_FFFF);
        chk({31'h0000_0000, err}, 32'h0000_0001);
        // a write while busy is dropped; the vector call still lands
        preset();
        apb(1'h1, IDX_INSTR, 32'h0000_40D4);
        apb(1'h1, IDX_CTRL, 32'h0000_0001);
        apb(1'h1, IDX_INSTR, 32'h0000_0000);
        chk({31'h0000_0000, err}, 32'h0000_0001);
        wait_idle();
        rdchk(IDX_PC, 32'h0000_1A1B);
        // unknown opcode flags illegal and leaves pc alone
        run(24'h00_0000);
        chk({31'h0000_0000, rd[STAT_ILL]}, 32'h0000_0001);
        rdchk(IDX_PC, 32'h0000_1A1B);
        stop_test();
    end
endmodule
